/* frg_core_model.sv */
// Flash core stand-in that finishes automatic program and erase runs
`timescale 1ns/1ps
`default_nettype none
module frg_core_model #(
  parameter int DONE_DLY = 5
) (
  input  wire logic clk_in,
  input  wire logic resetn_in,
  input  wire logic start_in,
  input  wire logic err_req_in,
  output var  logic done_out,
  output var  logic err_out
);
  int cnt_ff;
  // Count from start to a done pulse; the error line only means
  // something beside done, so it wanders otherwise to catch early use
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_ff   <= 0;
      done_out <= 1'b0;
      err_out  <= 1'b0;
    end else begin
      done_out <= (cnt_ff == 1);
      err_out  <= (cnt_ff == 1) ? err_req_in : ~err_out;
      if (start_in) cnt_ff <= DONE_DLY;
      else if (cnt_ff != 0) cnt_ff <= cnt_ff - 1;
    end
  end
endmodule : frg_core_model
`default_nettype wire

/* frg_guard.sv */
// Flash RAM emulation guard: overlay, protection and programmer mode
//
// Decided for this implementation: the address-and-strobe port and the address map.
`default_nettype none
`timescale 1ns/1ps
module frg_guard #(
  parameter int unsigned WAIT_CYC = frg_pkg::WAIT_US * frg_pkg::CLK_MHZ
) (
  input  wire logic                        clk_in,
  input  wire logic                        resetn_in,
  input  wire logic [7:0]                  reg_addr_in,
  input  wire logic [31:0]                 reg_wdata_in,
  input  wire logic                        reg_wr_in,
  input  wire logic                        reg_rd_in,
  output logic      [31:0]                 reg_rdata_out,
  input  wire logic [frg_pkg::ADDR_W-1:0]  cpu_addr_in,
  input  wire logic                        cpu_rd_in,
  input  wire logic                        cpu_wr_in,
  input  wire logic                        timer_wr_in,
  output logic      [frg_pkg::ADDR_W-1:0]  mem_addr_out,
  output logic                             flash_sel_out,
  output logic                             ram_sel_out,
  output logic                             acc_err_out,
  input  wire logic                        mode_sel_2_in,
  input  wire logic                        mode_sel_1_in,
  input  wire logic                        mode_sel_0_in,
  input  wire logic                        flash_write_en_pin_in,
  output logic                             program_mode_out,
  output logic                             erase_mode_out,
  output logic                             nmi_mask_out,
  input  wire frg_pkg::frg_op_e            pm_cmd_in,
  input  wire logic                        pm_cmd_valid_in,
  input  wire logic                        auto_done_in,
  input  wire logic                        auto_err_in,
  output logic                             auto_start_out,
  output logic                             programmer_mode_out,
  output logic      [2:0]                  pm_status_out
);
  import frg_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic               ovl_en;
    logic [2:0]         ovl_area;
    logic               swe;
    logic               pgo;
    logic               ego;
    logic [WAIT_W-1:0]  wait_cnt;
    logic               order_err;
    logic               tmr_wr_d;
    logic [2:0]         mode_s1;
    logic [2:0]         mode_s2;
    logic               fwe_s1;
    logic               fwe_s2;
    logic [31:0]        rdata;
    logic [ADDR_W-1:0]  mem_addr;
    logic               flash_sel;
    logic               ram_sel;
    logic               acc_err;
    frg_pm_e            pm_state;
    logic               auto_start;
    logic [2:0]         pm_status;
  } frg_state_s;

  frg_state_s st_ff;
  frg_state_s nxt_st;
  logic       mode_user;
  logic       mode_pgmr;
  logic       ovl_act;
  logic       cpu_acc;

  // ---------------------------------------------------------------
  // Address decoders
  // ---------------------------------------------------------------
  // Flash erase block selected by the area field
  function automatic logic blk_hit(input logic [ADDR_W-1:0] a,
                                   input logic [2:0]        area);
    blk_hit = (a[ADDR_W-1:BLK_W] == {BLK_HI_ZERO, area});
  endfunction : blk_hit

  // Original location of the RAM emulation window
  function automatic logic win_hit(input logic [ADDR_W-1:0] a);
    win_hit = (a[ADDR_W-1:BLK_W] == RAM_WIN_BASE[ADDR_W-1:BLK_W]);
  endfunction : win_hit

  // Mode decode from synchronised pins
  assign mode_user = (st_ff.mode_s2 == MODE_USER);
  assign mode_pgmr = (st_ff.mode_s2 == MODE_PROGRAMMER);
  assign ovl_act   = st_ff.ovl_en && mode_user;
  assign cpu_acc   = cpu_rd_in || cpu_wr_in;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    // Pins come from outside, two flops before use
    nxt_st.mode_s1  = {mode_sel_2_in, mode_sel_1_in, mode_sel_0_in};
    nxt_st.mode_s2  = st_ff.mode_s1;
    nxt_st.fwe_s1   = flash_write_en_pin_in;
    nxt_st.fwe_s2   = st_ff.fwe_s1;
    nxt_st.tmr_wr_d = timer_wr_in;
    nxt_st.auto_start = 1'b0;

    // Register writes
    if (reg_wr_in) begin
      if (reg_addr_in == REG_OVL) begin
        nxt_st.ovl_en   = reg_wdata_in[OVL_EN_BIT];
        nxt_st.ovl_area = reg_wdata_in[2:0];
      end else if (reg_addr_in == REG_FCTL) begin
        nxt_st.swe = reg_wdata_in[SWE_BIT];
        nxt_st.pgo = reg_wdata_in[PGO_BIT];
        nxt_st.ego = reg_wdata_in[EGO_BIT];
      end else if (reg_addr_in == REG_ERR) begin
        if (reg_wdata_in[0]) begin
          nxt_st.order_err = 1'b0;
        end
      end
    end

    // Low write enable pin drops all program controls
    if (!st_ff.fwe_s2) begin
      nxt_st.swe = 1'b0;
      nxt_st.pgo = 1'b0;
      nxt_st.ego = 1'b0;
    end

    // Clear wait starts when write enable falls; status shows it
    if (st_ff.swe && !nxt_st.swe) begin
      nxt_st.wait_cnt = WAIT_W'(WAIT_CYC);
    end else if (st_ff.wait_cnt != '0) begin
      nxt_st.wait_cnt = st_ff.wait_cnt - 1'b1;
    end

    // ROM write right after a timer write is flagged; set wins
    if (cpu_wr_in && st_ff.tmr_wr_d &&
        cpu_addr_in[ADDR_W-1:ADDR_W-8] != RAM_PAGE) begin
      nxt_st.order_err = 1'b1;
    end

    // CPU access routing, answered one cycle later
    nxt_st.flash_sel = 1'b0;
    nxt_st.ram_sel   = 1'b0;
    nxt_st.acc_err   = 1'b0;
    nxt_st.mem_addr  = cpu_addr_in;
    if (cpu_acc && ovl_act && blk_hit(cpu_addr_in, st_ff.ovl_area)) begin
      nxt_st.ram_sel  = 1'b1;
      nxt_st.mem_addr = {RAM_WIN_BASE[ADDR_W-1:BLK_W],
                         cpu_addr_in[BLK_W-1:0]};
    end else if (cpu_acc && ovl_act && win_hit(cpu_addr_in)) begin
      nxt_st.acc_err  = 1'b1;
    end else if (cpu_acc &&
                 cpu_addr_in[ADDR_W-1:ADDR_W-8] == RAM_PAGE) begin
      nxt_st.ram_sel  = 1'b1;
    end else if (cpu_acc) begin
      nxt_st.flash_sel = 1'b1;
    end

    // Programmer mode operations; auto ops need the pin high
    case (st_ff.pm_state)
      PM_READ, PM_STATUS: begin
        if (mode_pgmr && pm_cmd_valid_in) begin
          if ((pm_cmd_in == OP_PROG || pm_cmd_in == OP_ERASE) &&
              st_ff.fwe_s2) begin
            nxt_st.pm_state   = PM_AUTO;
            nxt_st.auto_start = 1'b1;
            nxt_st.pm_status  = 3'h1;
          end else if (pm_cmd_in == OP_STATUS) begin
            nxt_st.pm_state = PM_STATUS;
          end else if (pm_cmd_in == OP_READ) begin
            nxt_st.pm_state = PM_READ;
          end
        end
      end
      PM_AUTO: begin
        // Completion is taken from the auto_done_in pulse of the core
        if (auto_done_in) begin
          nxt_st.pm_state = PM_STATUS;
          nxt_st.pm_status[PS_BUSY_BIT] = 1'b0;
          nxt_st.pm_status[PS_DONE_BIT] = 1'b1;
          nxt_st.pm_status[PS_ERR_BIT]  = auto_err_in;
        end
      end
      default: begin
        nxt_st.pm_state = PM_READ;
      end
    endcase
    if (!mode_pgmr) begin
      nxt_st.pm_state = PM_READ;
    end

    // Register reads, data in the next cycle only
    nxt_st.rdata = ZERO_WORD;
    if (reg_rd_in) begin
      if (reg_addr_in == REG_OVL) begin
        nxt_st.rdata[OVL_EN_BIT] = st_ff.ovl_en;
        nxt_st.rdata[2:0]        = st_ff.ovl_area;
      end else if (reg_addr_in == REG_FCTL) begin
        nxt_st.rdata[SWE_BIT] = st_ff.swe;
        nxt_st.rdata[PGO_BIT] = st_ff.pgo;
        nxt_st.rdata[EGO_BIT] = st_ff.ego;
      end else if (reg_addr_in == REG_STAT) begin
        nxt_st.rdata[ST_OVL_BIT]  = ovl_act;
        nxt_st.rdata[ST_PROT_BIT] = st_ff.ovl_en || !st_ff.swe;
        nxt_st.rdata[ST_PGM_BIT]  = program_mode_out;
        nxt_st.rdata[ST_ERS_BIT]  = erase_mode_out;
        nxt_st.rdata[ST_WAIT_BIT] = (st_ff.wait_cnt != '0);
        nxt_st.rdata[ST_PMOD_BIT] = mode_pgmr;
      end else if (reg_addr_in == REG_ERR) begin
        nxt_st.rdata[0] = st_ff.order_err;
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Reset leaves overlay off so flash is at its own addresses
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Emulation protection overrides the go bits for every block
  assign program_mode_out = st_ff.swe && st_ff.pgo &&
                            !st_ff.ovl_en;
  assign erase_mode_out   = st_ff.swe && st_ff.ego &&
                            !st_ff.ovl_en;
  // Masking is offered as a help; software still owns NMI policy
  assign nmi_mask_out     = program_mode_out || erase_mode_out ||
                            ovl_act;
  assign reg_rdata_out       = st_ff.rdata;
  assign mem_addr_out        = st_ff.mem_addr;
  assign flash_sel_out       = st_ff.flash_sel;
  assign ram_sel_out         = st_ff.ram_sel;
  assign acc_err_out         = st_ff.acc_err;
  assign auto_start_out      = st_ff.auto_start;
  assign programmer_mode_out = mode_pgmr;
  assign pm_status_out       = st_ff.pm_status;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  sequence s_ovl_off_wr;
    reg_wr_in && reg_addr_in == REG_OVL && !reg_wdata_in[OVL_EN_BIT];
  endsequence
  sequence s_blk_rd;
    cpu_rd_in && blk_hit(cpu_addr_in, st_ff.ovl_area);
  endsequence
  sequence s_auto_cmd;
    mode_pgmr && pm_cmd_valid_in && pm_cmd_in == OP_PROG &&
    st_ff.fwe_s2 && st_ff.pm_state != PM_AUTO;
  endsequence

  a_overlay_route: assert property (
    cpu_acc && ovl_act && blk_hit(cpu_addr_in, st_ff.ovl_area) |=>
    ram_sel_out && !flash_sel_out &&
    mem_addr_out[BLK_W-1:0] == $past(cpu_addr_in[BLK_W-1:0]))
    else $error("Overlaid block access not sent to RAM window");
  a_window_block: assert property (
    cpu_acc && ovl_act && win_hit(cpu_addr_in) |=>
    acc_err_out && !ram_sel_out && !flash_sel_out)
    else $error("RAM window origin reachable during overlay");
  a_mode_gate: assert property (
    cpu_acc && !mode_user && blk_hit(cpu_addr_in, st_ff.ovl_area) |=>
    flash_sel_out && !ram_sel_out)
    else $error("Overlay active outside user modes");
  a_overlay_release: assert property (
    s_ovl_off_wr ##1 s_blk_rd |=> flash_sel_out && !ram_sel_out)
    else $error("Flash not restored after overlay release");
  a_protect_all: assert property (
    st_ff.ovl_en && st_ff.swe && st_ff.pgo |-> !program_mode_out)
    else $error("Program mode entered during emulation");
  a_no_erase_ram: assert property (
    st_ff.ovl_en |-> !erase_mode_out)
    else $error("Erase mode entered during emulation");
  a_protect_hold: assert property (
    st_ff.ovl_en [*2] |-> !program_mode_out && !erase_mode_out)
    else $error("Block left unprotected with overlay on");
  a_auto_start: assert property (
    s_auto_cmd |=> auto_start_out && pm_status_out[PS_BUSY_BIT]
    ##1 !auto_start_out)
    else $error("Auto operation start pulse wrong");
  a_auto_status: assert property (
    st_ff.pm_state == PM_AUTO && auto_done_in && mode_pgmr |=>
    pm_status_out[PS_DONE_BIT] && !pm_status_out[PS_BUSY_BIT] &&
    pm_status_out[PS_ERR_BIT] == $past(auto_err_in))
    else $error("Status not updated after auto operation");
  a_reset_clear: assert property (
    $rose(resetn_in) |-> !st_ff.ovl_en && st_ff.ovl_area == 3'h0)
    else $error("Overlay control not cleared by reset");
  a_clear_wait: assert property (
    $fell(st_ff.swe) |-> st_ff.wait_cnt == WAIT_W'(WAIT_CYC))
    else $error("Clear wait not started on enable drop");

endmodule : frg_guard
`default_nettype wire

/* frg_guard_tb.sv */
// Self-checking bench for the flash RAM emulation guard
`timescale 1ns/1ps
`default_nettype none
module frg_guard_tb;
  import frg_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  localparam int WAIT_SIM = 8;  // Short clear wait keeps the run brief
  logic              clk_in    = 1'b0;
  logic              resetn_in = 1'b0;
  logic [7:0]        reg_addr  = 8'h00;
  logic [31:0]       reg_wdata = 32'h00000000;
  logic              reg_wr    = 1'b0;
  logic              reg_rd    = 1'b0;
  logic [31:0]       rdata;
  logic [ADDR_W-1:0] cpu_addr  = 24'h000000;
  logic              cpu_rd    = 1'b0;
  logic              cpu_wr    = 1'b0;
  logic              timer_wr  = 1'b0;
  logic [ADDR_W-1:0] mem_addr;
  logic              flash_sel, ram_sel, acc_err;
  logic [2:0]        mode_sel  = 3'h6;
  logic              fwe_pin   = 1'b1;
  logic              pgm_mode, ers_mode, nmi_mask;
  frg_op_e           pm_cmd    = OP_READ;
  logic              pm_valid  = 1'b0;
  logic              err_req   = 1'b0;
  logic              done, err, start, pm_mode;
  logic [2:0]        pm_stat;
  int                fails     = 0;
  int                checks    = 0;
  int                cycles    = 0;

  frg_guard #(.WAIT_CYC(WAIT_SIM)) frg_guard_inst (
    .clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr),
    .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
    .reg_rdata_out(rdata), .cpu_addr_in(cpu_addr), .cpu_rd_in(cpu_rd),
    .cpu_wr_in(cpu_wr), .timer_wr_in(timer_wr), .mem_addr_out(mem_addr),
    .flash_sel_out(flash_sel), .ram_sel_out(ram_sel),
    .acc_err_out(acc_err), .mode_sel_2_in(mode_sel[2]),
    .mode_sel_1_in(mode_sel[1]), .mode_sel_0_in(mode_sel[0]),
    .flash_write_en_pin_in(fwe_pin), .program_mode_out(pgm_mode),
    .erase_mode_out(ers_mode), .nmi_mask_out(nmi_mask),
    .pm_cmd_in(pm_cmd), .pm_cmd_valid_in(pm_valid),
    .auto_done_in(done), .auto_err_in(err), .auto_start_out(start),
    .programmer_mode_out(pm_mode), .pm_status_out(pm_stat));

  frg_core_model frg_core_model_inst (
    .clk_in(clk_in), .resetn_in(resetn_in), .start_in(start),
    .err_req_in(err_req), .done_out(done), .err_out(err));

  // ---------------------------------------------------------------
  // Clock, timeout and report
  // ---------------------------------------------------------------
  always #10 clk_in = ~clk_in;
  // A hang anywhere ends the run as a failure
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // ---------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_in);
    reg_wr <= 1'b0;
    #1;
  endtask : reg_write
  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [31:0] m, input logic [31:0] e);
    @(posedge clk_in);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_in);
    reg_rd <= 1'b0;
    #1 chk(what, e, rdata & m);
  endtask : rd_chk
  task automatic cpu_acc(input logic w, input logic [23:0] a);
    @(posedge clk_in);
    cpu_rd   <= !w;
    cpu_wr   <= w;
    cpu_addr <= a;
    @(posedge clk_in);
    cpu_rd <= 1'b0;
    cpu_wr <= 1'b0;
    #1;
  endtask : cpu_acc
  task automatic pm_op(input frg_op_e c);
    @(posedge clk_in);
    pm_valid <= 1'b1;
    pm_cmd   <= c;
    @(posedge clk_in);
    pm_valid <= 1'b0;
    #1;
  endtask : pm_op
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_overlay();
    rd_chk("ovl reset", REG_OVL, 32'hFFFFFFFF, 32'h0);
    rd_chk("unmapped", 8'h10, 32'hFFFFFFFF, 32'h0);
    reg_write(REG_OVL, 32'h8);
    cpu_acc(1'b0, 24'h000123);
    chk("ram sel", 1, ram_sel);
    chk("flash sel", 0, flash_sel);
    chk("ram addr", 32'hFFF123, mem_addr);
    cpu_acc(1'b1, 24'h000FFC);
    chk("ram addr wr", 32'hFFFFFC, mem_addr);
    cpu_acc(1'b0, 24'hFFF010);
    chk("origin err", 1, acc_err);
    chk("nmi mask", 1, nmi_mask);
    rd_chk("status ovl", REG_STAT, 32'h3, 32'h3);
  endtask : t_overlay
  // Area 5 with enable set must still block program and erase
  task automatic t_protect();
    reg_write(REG_OVL, 32'hD);
    reg_write(REG_FCTL, 32'h1);
    reg_write(REG_FCTL, 32'h3);
    chk("prog blocked", 0, pgm_mode);
    reg_write(REG_FCTL, 32'h5);
    chk("erase blocked", 0, ers_mode);
  endtask : t_protect
  task automatic t_release();
    // Access in the very cycle after the release write lands
    @(posedge clk_in);
    reg_wr    <= 1'b1;
    reg_addr  <= REG_OVL;
    reg_wdata <= 32'h0;
    @(posedge clk_in);
    reg_wr   <= 1'b0;
    cpu_rd   <= 1'b1;
    cpu_addr <= 24'h000123;
    @(posedge clk_in);
    cpu_rd <= 1'b0;
    #1 chk("flash back", 1, flash_sel);
    chk("erase enters", 1, ers_mode);
    chk("flash addr", 32'h000123, mem_addr);
    cpu_acc(1'b0, 24'hFFF010);
    chk("ram origin", 1, ram_sel & !acc_err);
    reg_write(REG_FCTL, 32'h3);
    chk("prog enters", 1, pgm_mode);
    reg_write(REG_FCTL, 32'h1);
    reg_write(REG_FCTL, 32'h0);
    rd_chk("wait busy", REG_STAT, 32'h10, 32'h10);
    repeat (WAIT_SIM + 4) @(posedge clk_in);
    rd_chk("wait over", REG_STAT, 32'h10, 32'h0);
  endtask : t_release
  task automatic t_mode();
    @(posedge clk_in);
    mode_sel <= 3'h7;
    repeat (4) @(posedge clk_in);
    reg_write(REG_OVL, 32'h8);
    cpu_acc(1'b0, 24'h000123);
    chk("no ovl mode", 1, flash_sel & !ram_sel);
    reg_write(REG_OVL, 32'h0);
    @(posedge clk_in);
    mode_sel <= 3'h6;
  endtask : t_mode
  // A write right after a timer write is flagged; one gap is not
  task automatic t_order();
    @(posedge clk_in);
    timer_wr <= 1'b1;
    @(posedge clk_in);
    timer_wr <= 1'b0;
    cpu_wr   <= 1'b1;
    cpu_addr <= 24'h000100;
    @(posedge clk_in);
    cpu_wr <= 1'b0;
    rd_chk("order err", REG_ERR, 32'h1, 32'h1);
    reg_write(REG_ERR, 32'h1);
    @(posedge clk_in);
    timer_wr <= 1'b1;
    @(posedge clk_in);
    timer_wr <= 1'b0;
    cpu_acc(1'b1, 24'h000100);
    rd_chk("order gap", REG_ERR, 32'h1, 32'h0);
  endtask : t_order
  // Overlay set before a mid-run reset must be gone after it; the
  // reset only comes once the write enable clear wait has run out
  task automatic t_reset();
    reg_write(REG_OVL, 32'h8);
    reg_write(REG_FCTL, 32'h1);
    reg_write(REG_FCTL, 32'h0);
    repeat (WAIT_SIM + 4) @(posedge clk_in);
    resetn_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    #1 chk("rst nmi", 0, nmi_mask);
    @(posedge clk_in);
    resetn_in <= 1'b1;
    rd_chk("ovl after rst", REG_OVL, 32'hFFFFFFFF, 32'h0);
    cpu_acc(1'b0, 24'h000123);
    chk("flash after rst", 1, flash_sel);
  endtask : t_reset
  task automatic t_prog();
    pm_op(OP_ERASE);
    chk("start user", 0, start);
    // One clock here stands for the multiplied programmer core clock
    @(posedge clk_in);
    mode_sel <= 3'h3;
    repeat (3) @(posedge clk_in);
    #1 chk("pm mode", 1, pm_mode);
    for (int i = 0; i < 2; i++) begin
      err_req <= i[0];
      pm_op(i ? OP_ERASE : OP_PROG);
      chk("auto start", 1, start);
      chk("busy", 32'h1, pm_stat);
      // Look only once the status register has settled after an edge
      for (int k = 0; k < 20; k++) begin
        if (pm_stat[1] !== 1'b1) begin
          @(posedge clk_in);
          #1;
        end
      end
      #1 chk("done stat", {i[0], 2'h2}, pm_stat);
    end
    pm_op(OP_STATUS);
    chk("status op", 1, !start & pm_stat[1]);
    pm_op(OP_READ);
    chk("read op", 0, start);
    @(posedge clk_in);
    fwe_pin <= 1'b0;
    repeat (4) @(posedge clk_in);
    pm_op(OP_PROG);
    chk("fwe low", 0, start);
    fwe_pin <= 1'b1;
  endtask : t_prog
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk_in);
    resetn_in <= 1'b1;
    t_overlay();
    t_protect();
    t_release();
    t_mode();
    t_order();
    t_reset();
    t_prog();
    final_report();
  end
endmodule : frg_guard_tb
`default_nettype wire

/* frg_pkg.sv */
// Constants shared by the flash RAM emulation guard
`default_nettype none
package frg_pkg;
  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned WAIT_US = 100;  // Write enable clear wait
  localparam int unsigned WAIT_W  = 13;
  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_OVL  = 8'h00;
  localparam logic [7:0] REG_FCTL = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_ERR  = 8'h0C;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned OVL_EN_BIT   = 3;
  localparam int unsigned SWE_BIT      = 0;
  localparam int unsigned PGO_BIT      = 1;
  localparam int unsigned EGO_BIT      = 2;
  localparam int unsigned ST_OVL_BIT   = 0;
  localparam int unsigned ST_PROT_BIT  = 1;
  localparam int unsigned ST_PGM_BIT   = 2;
  localparam int unsigned ST_ERS_BIT   = 3;
  localparam int unsigned ST_WAIT_BIT  = 4;
  localparam int unsigned ST_PMOD_BIT  = 5;
  localparam int unsigned PS_BUSY_BIT  = 0;
  localparam int unsigned PS_DONE_BIT  = 1;
  localparam int unsigned PS_ERR_BIT   = 2;
  // ---------------------------------------------------------------
  // Address map
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W   = 24;
  localparam int unsigned BLK_W    = 12;  // Erase block of 4 KB
  localparam logic [ADDR_W-1:0] RAM_WIN_BASE = 24'hFFF000;
  localparam logic [7:0] RAM_PAGE  = 8'hFF;
  localparam logic [ADDR_W-BLK_W-4:0] BLK_HI_ZERO = 9'h000;
  localparam logic [31:0] ZERO_WORD = 32'h00000000;
  // ---------------------------------------------------------------
  // Mode pin codes
  // ---------------------------------------------------------------
  localparam logic [2:0] MODE_PROGRAMMER = 3'h3;
  localparam logic [2:0] MODE_USER       = 3'h6;
  // ---------------------------------------------------------------
  // Programmer mode operations and states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_READ   = 2'h0,
    OP_PROG   = 2'h1,
    OP_ERASE  = 2'h2,
    OP_STATUS = 2'h3
  } frg_op_e;
  typedef enum logic [1:0] {
    PM_READ   = 2'h0,
    PM_AUTO   = 2'h1,
    PM_STATUS = 2'h3
  } frg_pm_e;
endpackage : frg_pkg
`default_nettype wire
